// ### isf_addr_filter.sv
`timescale 1ns/1ps
// What this block does
// - Own address bits 7:1, software read/write
// - Match sets interrupt and address-match flags
// - Own address changed only by software write, ignored as master
// - SDA fall while SCL high starts
// - Check SDA low, SCL high before address
// - Setup bit 7 enable, bits 6:0 count
// - Enable clear gives one sample, one cycle
// - Enabled gives count plus one samples
// - Samples one clock period apart
// - Setup and own address reset to zero
// - Read/write bit picks mode, shows transmit flag
module isf_addr_filter
  import isf_pkg::*;
(
  // Clock, reset, enable
  input  logic                      CLK,
  input  logic                      NRST,
  input  logic                      CE,
  // Avalon-MM slave
  input  logic [isf_pkg::ADDR_W-1:0] ADDRESS,
  input  logic                      READ,
  input  logic                      WRITE,
  input  logic [isf_pkg::DATA_W-1:0] WRITEDATA,
  output logic [isf_pkg::DATA_W-1:0] READDATA,
  output logic                      WAITREQUEST,
  // Interrupt
  output logic                      IRQ,
  // I2C lines
  input  logic                      SCL_IN,
  input  logic                      SDA_IN,
  output logic                      SDA_OUT,
  output logic                      SDA_OE
);
  // ==========================================================================
  // Declarations
  isf_line_if     ln ();                   // Clean line bundle
  isf_state_type  state_reg, state_next;   // Engine state
  logic [6:0]     cnt_reg, cnt_next;       // Samples left after this one
  logic [2:0]     bit_reg, bit_next;       // Address bit index
  logic [7:0]     shift_reg, shift_next;   // Address shifter
  logic           oe_reg, oe_next;         // SDA drive
  logic           tx_reg, tx_next;         // Transmission mode
  logic [7:0]     setup_reg, setup_next;   // start_sampling_setup
  logic [7:0]     own_reg, own_next;       // own_slave_address
  logic [1:0]     ctrl_reg, ctrl_next;     // engine_control_reg
  logic [2:0]     stat_reg, stat_next;     // Sticky events
  logic [2:0]     mask_reg, mask_next;     // Interrupt mask
  logic [31:0]    rd_reg, rd_next;         // Read data
  logic           wait_reg, wait_next;     // Waitrequest
  logic           irq_reg, irq_next;       // Interrupt output
  logic           hit;                     // Request taken this cycle
  logic           wr_go;                   // Write completes this cycle
  logic           start_det;               // Start edge seen
  logic           stop_det;                // Stop edge seen
  logic           line_ok;                 // Start still holds
  logic           match_ev;                // Address matched
  logic [2:0]     ev;                      // Events this cycle
  logic [6:0]     load_cnt;                // Count loaded on start

  // Register index decode, used by reads and writes
  function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a[ADDR_W-1:2] == idx;
  endfunction

  // ==========================================================================
  // Line synchroniser
  isf_line_sync u_sync (
    .clk    (CLK),
    .nrst   (NRST),
    .ce     (CE),
    .scl_in (SCL_IN),
    .sda_in (SDA_IN),
    .lines  (ln.prod)
  );

  // ==========================================================================
  // Start engine
  // Start and stop seen only on clean lines
  always_comb begin
    start_det = ln.sda_fall & ln.scl_hi;
    stop_det  = ln.sda_rise & ln.scl_hi;
    line_ok   = ~ln.sda_hi & ln.scl_hi;
    load_cnt  = setup_reg[SS_EN_BIT] ? setup_reg[CNT_HI:0] : 7'h00;
  end

  // Next state of the engine
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    shift_next = shift_reg;
    oe_next    = oe_reg;
    tx_next    = tx_reg;
    match_ev   = 1'b0;
    ev         = EV_RST;
    if (CE) begin
      case (state_reg)
        // Master mode leaves the engine idle
        ST_IDLE: begin
          if (start_det && ctrl_reg[CTL_SLV]) begin
            state_next = ST_SAMPLE;
            cnt_next   = load_cnt;
          end
        end
        // One sample per clock, first one cycle after the edge
        ST_SAMPLE: begin
          if (!line_ok) begin
            state_next   = ST_IDLE;
            ev[ST_REJ]   = 1'b1;
          end else if (cnt_reg == 7'h00) begin
            state_next   = ST_ADDR;
            bit_next     = 3'h0;
            ev[ST_VALID] = 1'b1;
          end else begin
            cnt_next     = cnt_reg - 7'h01;
          end
        end
        // Shift on each SCL rise, MSB first
        ST_ADDR: begin
          if (ln.scl_rise) begin
            shift_next = {shift_reg[6:0], ln.sda_hi};
            bit_next   = bit_reg + 3'h1;
            if (bit_reg == BIT_LAST) begin
              if (shift_reg[6:0] == own_reg[ADR_HI:ADR_LO] && ctrl_reg[CTL_SLV]) begin
                match_ev    = 1'b1;
                ev[ST_INTR] = 1'b1;
                tx_next     = ln.sda_hi;
                state_next  = ST_ACK;
              end else begin
                state_next  = ST_IDLE;
              end
            end
          end
        end
        // Drive low through the ninth clock
        ST_ACK: begin
          if (ln.scl_fall) begin
            oe_next = ~oe_reg;
            if (oe_reg) begin
              state_next = ST_HOLD;
            end
          end
        end
        // Data path lives elsewhere
        ST_HOLD: begin
          state_next = ST_HOLD;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      // Stop or repeated start overrides
      if (state_reg != ST_IDLE && state_reg != ST_SAMPLE) begin
        if (stop_det) begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
          tx_next    = 1'b0;
        end else if (start_det && ctrl_reg[CTL_SLV]) begin
          state_next = ST_SAMPLE;
          cnt_next   = load_cnt;
          oe_next    = 1'b0;
          tx_next    = 1'b0;
        end
      end
    end
  end

  // Engine registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 7'h00;
      bit_reg   <= 3'h0;
      shift_reg <= 8'h00;
      oe_reg    <= 1'b0;
      tx_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      shift_reg <= shift_next;
      oe_reg    <= oe_next;
      tx_reg    <= tx_next;
    end
  end

  // ==========================================================================
  // Register file
  // Answer one cycle after the request is seen
  always_comb begin
    hit       = CE && (READ || WRITE) && wait_reg;
    wr_go     = CE && WRITE && !wait_reg;
    wait_next = CE ? !hit : wait_reg;
    rd_next   = rd_reg;
    if (hit && READ) begin
      rd_next = 32'h0;
      if (sel(ADDRESS, IDX_OWN)) rd_next[7:0] = own_reg;
      if (sel(ADDRESS, IDX_SETUP)) rd_next[7:0] = setup_reg;
      if (sel(ADDRESS, IDX_CTRL)) rd_next[1:0] = ctrl_reg;
      if (sel(ADDRESS, IDX_STAT)) rd_next[ST_TX:0] = {tx_reg, 1'b0, stat_reg};
      if (sel(ADDRESS, IDX_MASK)) rd_next[2:0] = mask_reg;
    end
    own_next   = (wr_go && sel(ADDRESS, IDX_OWN)) ? {WRITEDATA[ADR_HI:ADR_LO], 1'b0} : own_reg;
    setup_next = (wr_go && sel(ADDRESS, IDX_SETUP)) ? WRITEDATA[7:0] : setup_reg;
    mask_next  = (wr_go && sel(ADDRESS, IDX_MASK)) ? WRITEDATA[2:0] : mask_reg;
    ctrl_next  = (wr_go && sel(ADDRESS, IDX_CTRL)) ? WRITEDATA[1:0] : ctrl_reg;
    if (match_ev) ctrl_next[CTL_ADDR] = 1'b1;
    stat_next  = stat_reg;
    if (wr_go && sel(ADDRESS, IDX_STAT)) stat_next = stat_reg & ~WRITEDATA[2:0];
    stat_next  = stat_next | ev;
    irq_next   = |(stat_next & mask_next);
  end

  // Register storage
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      setup_reg <= SETUP_RST;
      own_reg   <= OWN_RST;
      ctrl_reg  <= CTRL_RST;
      stat_reg  <= EV_RST;
      mask_reg  <= EV_RST;
      rd_reg    <= 32'h0;
      wait_reg  <= 1'b1;
      irq_reg   <= 1'b0;
    end else begin
      setup_reg <= setup_next;
      own_reg   <= own_next;
      ctrl_reg  <= ctrl_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rd_reg    <= rd_next;
      wait_reg  <= wait_next;
      irq_reg   <= irq_next;
    end
  end

  // Outputs straight from flops, SDA_OUT tied low, so SDA only ever pulled low
  assign READDATA    = rd_reg;
  assign WAITREQUEST = wait_reg;
  assign IRQ         = irq_reg;
  assign SDA_OUT     = 1'b0;
  assign SDA_OE      = oe_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_answer;
    !WAITREQUEST ##1 WAITREQUEST;
  endsequence
  sequence s_start_seen;
    CE && state_reg == ST_IDLE && start_det && ctrl_reg[CTL_SLV];
  endsequence

  a_bus_answer_once: assert property ((CE && hit) ##1 CE |-> s_answer)
    else $error("waitrequest not a single low cycle");
  a_start_enters_sample: assert property (s_start_seen |=> state_reg == ST_SAMPLE && cnt_reg == $past(load_cnt))
    else $error("start edge not taken");
  a_sample_last_ends: assert property ((CE && state_reg == ST_SAMPLE && cnt_reg == 7'h00) |=> state_reg != ST_SAMPLE)
    else $error("sampling did not end");
  a_sample_count_step: assert property ((CE && state_reg == ST_SAMPLE && line_ok && cnt_reg != 7'h00)
      |=> state_reg == ST_SAMPLE && cnt_reg == $past(cnt_reg) - 7'h01)
    else $error("sample count wrong");
  a_sample_reject: assert property ((CE && state_reg == ST_SAMPLE && !line_ok) |=> state_reg == ST_IDLE && stat_reg[ST_REJ])
    else $error("bad start not rejected");
  a_master_stays_idle: assert property ((CE && !ctrl_reg[CTL_SLV] && state_reg == ST_IDLE) |=> state_reg == ST_IDLE)
    else $error("engine left idle as master");
  a_own_addr_stable: assert property (!(wr_go && sel(ADDRESS, IDX_OWN)) |=> $stable(own_reg))
    else $error("own address changed without write");
  a_match_flags: assert property ((CE && match_ev) |=> ctrl_reg[CTL_ADDR] && stat_reg[ST_INTR])
    else $error("match flags not set");
  a_match_tx_mode: assert property ((CE && match_ev) |=> tx_reg == $past(ln.sda_hi) && state_reg == ST_ACK)
    else $error("transmit mode wrong");
endmodule // isf_addr_filter

// ### isf_addr_filter_bench.sv
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench for the address and start filter
module isf_addr_filter_bench;
  import isf_pkg::*;
  logic              clk;              // 100 MHz clock
  logic              nrst;             // Active-low reset
  logic [ADDR_W-1:0] address;          // Avalon address
  logic              read;             // Avalon read
  logic              write;            // Avalon write
  logic [DATA_W-1:0] writedata;        // Avalon write data
  logic [DATA_W-1:0] readdata;         // Avalon read data
  logic              waitrequest;      // Avalon wait
  logic              irq;              // Interrupt level
  logic              scl_m;            // Master SCL
  logic              sda_m;            // Master SDA
  logic              sda_out;          // Unused, always zero
  logic              sda_oe;           // Slave pulls SDA low
  wire logic         sda_line;         // Pull-up wired-AND
  int                fails;            // Mismatch count
  int                samples_checked;  // Comparison count
  int                cycles;           // Timeout counter
  logic [31:0]       rdv;              // Last read value
  logic              ack;              // ACK level seen by master
  logic [7:0]        g_set [6] = '{8'h00, 8'h7f, 8'h80, 8'h85, 8'hff, 8'hff};
  int                g_ns  [6] = '{20, 20, 20, 20, 1000, 1400};
  logic              g_ok  [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  // Open drain with pull-up: low if either party pulls
  assign sda_line = sda_m & ~sda_oe;

  isf_addr_filter i_dut (
    .CLK(clk), .NRST(nrst), .CE(1'b1),
    .ADDRESS(address), .READ(read), .WRITE(write), .WRITEDATA(writedata),
    .READDATA(readdata), .WAITREQUEST(waitrequest), .IRQ(irq),
    .SCL_IN(scl_m), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe)
  );
  isf_i2c_master i_mst (.scl(scl_m), .sda(sda_m), .sda_line(sda_line));

  // ==========================================================================
  // Clock and hang guard
  // 100 MHz oscillator, so high-speed starts are usable
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial cycles = 0;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Far beyond the 1300 or so cycles the tests need
    if (cycles == 30000) begin
      fails++;
      conclude();
    end
  end

  // ==========================================================================
  // Bus tasks: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address   <= {idx, 2'b00};
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    rdv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 100) fails++;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Read a register and compare the masked value
  task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] m,
                      input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(what, exp, rdv & m);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    nrst = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, unmapped place
    rchk("setup", IDX_SETUP, '1, 32'h0);
    rchk("own", IDX_OWN, '1, 32'h0);
    rchk("status", IDX_STAT, '1, 32'h0);
    rchk("unmapped", 8'h10, '1, 32'h0);
    // Field access: own bit 0 reads zero
    bus(1'b1, IDX_SETUP, 32'hff);
    rchk("setup rw", IDX_SETUP, '1, 32'hff);
    bus(1'b1, IDX_OWN, 32'hab);
    rchk("own rw", IDX_OWN, '1, 32'haa);
    $display("test registers done");

    // Sample count table, short and long starts
    bus(1'b1, IDX_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, IDX_SETUP, {24'h0, g_set[i]});
      i_mst.glitch(g_ns[i]);
      rchk("start verdict", IDX_STAT, 32'h6, g_ok[i] ? 32'h2 : 32'h4);
      bus(1'b1, IDX_STAT, 32'h7);
    end
    $display("test start sampling done");

    // Matching address, read direction, interrupt masked first
    bus(1'b1, IDX_SETUP, 32'h8b);
    bus(1'b1, IDX_OWN, 32'h54);
    i_mst.start(500);
    i_mst.put_byte(8'h55, ack);
    chk("ack", 32'h0, {31'h0, ack});
    rchk("status", IDX_STAT, 32'h13, 32'h13);
    rchk("ctrl", IDX_CTRL, 32'h3, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, IDX_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, IDX_STAT, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    rchk("own kept", IDX_OWN, '1, 32'h54);
    i_mst.stop();
    bus(1'b1, IDX_CTRL, 32'h1);
    $display("test match read done");

    // Direction bit excluded from compare, write direction
    i_mst.start(500);
    i_mst.put_byte(8'h54, ack);
    chk("ack write dir", 32'h0, {31'h0, ack});
    rchk("tx flag", IDX_STAT, 32'h11, 32'h01);
    i_mst.stop();
    bus(1'b1, IDX_STAT, 32'h7);
    // Neighbour address is not acknowledged
    i_mst.start(500);
    i_mst.put_byte(8'h57, ack);
    chk("nack other", 32'h1, {31'h0, ack});
    rchk("no match", IDX_STAT, 32'h1, 32'h0);
    i_mst.stop();
    // Master mode ignores own address
    bus(1'b1, IDX_STAT, 32'h7);
    bus(1'b1, IDX_CTRL, 32'h0);
    i_mst.start(500);
    i_mst.put_byte(8'h55, ack);
    chk("master mode", 32'h1, {31'h0, ack});
    rchk("master status", IDX_STAT, 32'h7, 32'h0);
    i_mst.stop();
    $display("test address filter done");
    conclude();
  end
endmodule // isf_addr_filter_bench

// ### isf_i2c_master.sv
`timescale 1ns/1ps
// ============================================================================
// Behavioural bus master that drives the slave's SCL and SDA pins
module isf_i2c_master (
  // Lines driven by this master (released means high)
  output logic      scl,
  output logic      sda,
  // Resolved SDA wire
  input  wire logic sda_line
);
  // Idle bus: both lines released to the pull-ups
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // start, held
  // Hold is chosen by the caller so that it outlasts the sampling span
  task automatic start(input int hold_ns);
    // Step off the clock edge the caller returned on, so the pin never moves with it
    #2;
    sda = 1'b0;
    #(hold_ns);
    scl = 1'b0;
    #31;
  endtask

  // Eight bits MSB first, then one clock for the slave's ACK
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      #31;
      scl = 1'b1;
      #62.5;
      scl = 1'b0;
      #31.5;
    end
    // Release SDA so only the slave can pull it low
    sda = 1'b1;
    #31;
    scl = 1'b1;
    ack = sda_line;
    #62.5;
    scl = 1'b0;
    #31.5;
  endtask

  // Stop: SDA rises while SCL is high
  task automatic stop();
    // Off the clock edge, as for start
    #2;
    sda = 1'b0;
    #31;
    scl = 1'b1;
    #31;
    sda = 1'b1;
    #200;
  endtask

  // Short SDA dip with SCL high, a noise or short start
  task automatic glitch(input int low_ns);
    // Off the clock edge, so the dip spans a known number of samples
    #2;
    sda = 1'b0;
    #(low_ns);
    sda = 1'b1;
    #200;
  endtask
endmodule // isf_i2c_master

// ### isf_line_if.sv
`timescale 1ns/1ps
interface isf_line_if;
  // ==========================================================================
  // Clean bus line levels and edges
  logic scl_hi;    // Synchronised SCL level
  logic sda_hi;    // Synchronised SDA level
  logic sda_fall;  // SDA fell this cycle
  logic sda_rise;  // SDA rose this cycle
  logic scl_rise;  // SCL rose this cycle
  logic scl_fall;  // SCL fell this cycle
  modport prod (output scl_hi, sda_hi, sda_fall, sda_rise, scl_rise, scl_fall);
  modport cons (input scl_hi, sda_hi, sda_fall, sda_rise, scl_rise, scl_fall);
endinterface

// ### isf_line_sync.sv
`timescale 1ns/1ps
module isf_line_sync (
  // Clock, reset, enable
  input  logic        clk,
  input  logic        nrst,
  input  logic        ce,
  // Raw pins
  input  logic        scl_in,
  input  logic        sda_in,
  // Clean lines
  isf_line_if.prod    lines
);
  // ==========================================================================
  // Two-stage synchronisers plus one history stage for edges
  logic [1:0] s1_reg, s1_next;   // First stage, read only by s2
  logic [1:0] s2_reg, s2_next;   // Second stage, safe level
  logic [1:0] s3_reg, s3_next;   // Previous safe level

  // Next values, bit 1 is SCL, bit 0 is SDA
  always_comb begin
    s1_next = ce ? {scl_in, sda_in} : s1_reg;
    s2_next = ce ? s1_reg : s2_reg;
    s3_next = ce ? s2_reg : s3_reg;
  end

  // Idle bus is high, so reset to ones to avoid a false edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 2'h3;
      s2_reg <= 2'h3;
      s3_reg <= 2'h3;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // Edges from the safe stages only
  assign lines.scl_hi   = s2_reg[1];
  assign lines.sda_hi   = s2_reg[0];
  assign lines.sda_fall = s3_reg[0] & ~s2_reg[0];
  assign lines.sda_rise = ~s3_reg[0] & s2_reg[0];
  assign lines.scl_rise = ~s3_reg[1] & s2_reg[1];
  assign lines.scl_fall = s3_reg[1] & ~s2_reg[1];
endmodule // isf_line_sync

// ### isf_pkg.sv
package isf_pkg;
  // ==========================================================================
  // Bus and register map
  localparam int          ADDR_W     = 10;      // Byte address width
  localparam int          DATA_W     = 32;      // Avalon data width
  localparam logic [7:0]  IDX_SETUP  = 8'hdb;   // start_sampling_setup index
  localparam logic [7:0]  IDX_OWN    = 8'hdf;   // own_slave_address index
  localparam logic [7:0]  IDX_CTRL   = 8'he0;   // engine_control_reg index
  localparam logic [7:0]  IDX_STAT   = 8'he1;   // engine_status_reg index
  localparam logic [7:0]  IDX_MASK   = 8'he2;   // Interrupt mask index
  // ==========================================================================
  // Reset values
  localparam logic [7:0]  SETUP_RST  = 8'h00;
  localparam logic [7:0]  OWN_RST    = 8'h00;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [2:0]  EV_RST     = 3'h0;
  // ==========================================================================
  // Field positions
  localparam int          SS_EN_BIT  = 7;       // Sample-count enable
  localparam int          CNT_HI     = 6;       // Sample-count field top
  localparam int          ADR_HI     = 7;       // own_address_field top
  localparam int          ADR_LO     = 1;       // own_address_field bottom
  localparam int          CTL_SLV    = 0;       // Slave enable
  localparam int          CTL_ADDR   = 1;       // Address-match flag
  localparam int          ST_INTR    = 0;       // Address match interrupt
  localparam int          ST_VALID   = 1;       // Start validated
  localparam int          ST_REJ     = 2;       // Start rejected
  localparam int          ST_TX      = 4;       // Transmission mode (read only)
  localparam int          EV_W       = 3;       // Sticky event bits
  localparam logic [2:0]  BIT_LAST   = 3'h7;    // Last bit of address byte
  // ==========================================================================
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,  // Waiting for a start edge
    ST_SAMPLE = 3'b001,  // Validating the start
    ST_ADDR   = 3'b010,  // Shifting the address byte
    ST_ACK    = 3'b011,  // Driving the acknowledge bit
    ST_HOLD   = 3'b100   // Addressed, until stop or start
  } isf_state_type;
endpackage
